// file: hdl/slew_id_pkg.sv
// shared constants for the slew limit and identification register bank
package slew_id_pkg;
	// register word, address, field and product widths
	localparam int          REG_W              = 16;
	localparam int          ADDR_W             = 8;
	localparam int          TEMP_W             = 14;
	localparam int          LIMIT_W            = 13;
	localparam int          PERIOD_W           = 11;
	localparam int          PROD_W             = 25;

	// register offsets
	localparam logic [7:0]  ADDR_SLEW_LIMIT    = 8'h08;
	localparam logic [7:0]  ADDR_SERIAL_HIGH   = 8'h09;
	localparam logic [7:0]  ADDR_SERIAL_MID    = 8'h0a;
	localparam logic [7:0]  ADDR_SERIAL_LOW    = 8'h0b;
	localparam logic [7:0]  ADDR_PART_IDENTITY = 8'h0c;

	// slew limit field position and reset values
	localparam int          LIMIT_LSB          = 2;
	localparam int          LIMIT_MSB          = 14;
	localparam logic [12:0] LIMIT_RESET        = 13'h0140;
	localparam logic [15:0] SLEW_REG_RESET     = 16'h0500;

	// serial number slices
	localparam int          SERIAL_W           = 48;
	localparam int          SERIAL_HIGH_LSB    = 32;
	localparam int          SERIAL_MID_LSB     = 16;
	localparam int          SERIAL_LOW_LSB     = 0;

	// identity field positions
	localparam int          REV_LSB            = 12;
	localparam int          PART_CODE_LSB      = 0;

	// conversion period, times in their own units
	localparam int          CLK_PERIOD_NS      = 25;
	localparam int          MS_NS              = 1000000;
	localparam int          MS_PER_S           = 1000;
	localparam int          MS_CYCLES          = MS_NS / CLK_PERIOD_NS;
	localparam logic [10:0] PERIOD_MIN_MS      = 11'h006;
	localparam logic [10:0] PERIOD_MAX_MS      = 11'h7d0;
	localparam logic [10:0] PERIOD_DEFAULT_MS  = 11'h3e8;
	localparam logic [9:0]  MS_PER_S_W         = 10'h3e8;
endpackage : slew_id_pkg

// file: hdl/conv_period_timer.sv
// free-running conversion start timer with a clamped period in milliseconds
`timescale 1ns/1ps
`default_nettype none
module conv_period_timer
	import slew_id_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
)
(
	input  wire logic                mclk,          // system clock
	input  wire logic                rst_n,         // async reset, active low
	input  wire logic [PERIOD_W-1:0] period_req_ms, // requested period
	output logic                     conv_start_ff, // one-cycle start pulse
	output logic [PERIOD_W-1:0]      period_act_ff  // period of running cycle
);
	logic [31:0]         ms_cnt_ff;
	logic [PERIOD_W-1:0] per_cnt_ff;
	logic                ms_tick;
	logic [PERIOD_W-1:0] nxt_period;

	assign ms_tick = (ms_cnt_ff == 32'(MS_CYC - 1));

	// clamp the request into the legal window
	always_comb
	begin
		if (period_req_ms < PERIOD_MIN_MS)
			nxt_period = PERIOD_MIN_MS;
		else if (period_req_ms > PERIOD_MAX_MS)
			nxt_period = PERIOD_MAX_MS;
		else
			nxt_period = period_req_ms;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			ms_cnt_ff <= 32'h0;
		else if (ms_tick)
			ms_cnt_ff <= 32'h0;
		else
			ms_cnt_ff <= ms_cnt_ff + 32'h1;
	end

	// period counts whole milliseconds; new period takes effect at next start
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			per_cnt_ff    <= 11'h0;
			conv_start_ff <= 1'b0;
			period_act_ff <= PERIOD_DEFAULT_MS;
		end
		else
		begin
			conv_start_ff <= 1'b0;
			if (ms_tick)
			begin
				if (per_cnt_ff >= period_act_ff - 11'h1) // RULE_09
				begin
					per_cnt_ff    <= 11'h0;
					conv_start_ff <= 1'b1;
					period_act_ff <= nxt_period; // RULE_09
				end
				else
					per_cnt_ff <= per_cnt_ff + 11'h1;
			end
		end
	end
endmodule : conv_period_timer
`default_nettype wire

// file: hdl/slew_limit_and_id_registers.sv
// slew limit, serial number and identity registers with slew alert detection
// Function
// RULE_01 - slew limit is unsigned 13 bits, lsb 0.03125 degC per second
// RULE_02 - limit field sits in bits 14:2; bit 15 and 1:0 read zero
// RULE_03 - limit resets to 0140h, so the register reads 0500h
// RULE_04 - slew alert only when rise rate exceeds limit and source enabled
// RULE_05 - address 09h returns serial bits 47:32, read only
// RULE_06 - address 0ah returns serial bits 31:16, read only
// RULE_07 - address 0bh returns serial bits 15:0, fixed, writes ignored
// RULE_08 - address 0ch holds revision in 15:12, part code in 11:0
// RULE_09 - conversions start every second by default, period 6 ms to 2 s
// RULE_10 - register reads never disturb or restart the conversion cycle
// RULE_11 - rate is consecutive result difference over active period, rises only
// RULE_12 - alert enable bit 3 gates slew condition onto alert, default off
`timescale 1ns/1ps
`default_nettype none
module slew_limit_and_id_registers
	import slew_id_pkg::*;
#(
	parameter int                      MS_CYC              = MS_CYCLES,
	parameter logic [SERIAL_W-1:0]     TRACEABILITY_SERIAL = 48'h5a5a_0123_4567, // arbitrary
	parameter logic [3:0]              REVISION            = 4'h1,                // arbitrary
	parameter logic [11:0]             PART_CODE           = 12'h0a5               // arbitrary
)
(
	input  wire logic                              mclk,             // system clock
	input  wire logic                              rst_n,            // async reset, active low
	input  wire logic [slew_id_pkg::ADDR_W-1:0]    reg_addr,         // register address
	input  wire logic                              reg_wr_en,        // write strobe
	input  wire logic [slew_id_pkg::REG_W-1:0]     reg_wdata,        // write data
	input  wire logic                              reg_rd_en,        // read strobe
	output logic      [slew_id_pkg::REG_W-1:0]     reg_rdata_ff,     // read data
	output logic                                   reg_rd_hit_ff,    // read hit this bank
	input  wire logic                              slew_alert_en,    // alert enable bit 3
	input  wire logic [slew_id_pkg::PERIOD_W-1:0]  conv_period_ms,   // requested period
	input  wire logic                              temp_valid,       // conversion done pulse
	input  wire logic [slew_id_pkg::TEMP_W-1:0]    temp_result,      // signed result
	output logic                                   conv_start_ff,    // conversion start pulse
	output logic                                   slew_status_ff,   // raw slew condition
	output logic                                   slew_alert_ff     // gated slew alert
);
	import slew_id_pkg::*;

	logic [LIMIT_W-1:0]  limit_ff;
	logic [TEMP_W-1:0]   prev_temp_ff;
	logic                prev_valid_ff;
	logic [PERIOD_W-1:0] period_act;
	logic [PERIOD_W-1:0] cycle_period_ff;
	logic                timer_start;
	logic [TEMP_W:0]     diff;
	logic                rising;
	logic [PROD_W-1:0]   rise_scaled;
	logic [PROD_W-1:0]   limit_scaled;
	logic [REG_W-1:0]    nxt_rdata;
	logic                nxt_hit;

	// unsigned product sized to the comparison width
	function automatic logic [PROD_W-1:0] scale(input logic [PROD_W-1:0] a,
		input logic [PROD_W-1:0] b);
		logic [2*PROD_W-1:0] p;
		p = a * b;
		return p[PROD_W-1:0];
	endfunction : scale

	conv_period_timer #(
		.MS_CYC        (MS_CYC)
	) u_timer (
		.mclk          (mclk),
		.rst_n         (rst_n),
		.period_req_ms (conv_period_ms),
		.conv_start_ff (timer_start),
		.period_act_ff (period_act)
	);

	// timer runs independently of register traffic
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			conv_start_ff <= 1'b0;
		else
			conv_start_ff <= timer_start; // RULE_10
	end

	// period in force for the conversion now running
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			cycle_period_ff <= PERIOD_DEFAULT_MS;
		else if (timer_start)
			cycle_period_ff <= period_act; // RULE_09
	end

	// slew limit register, only the field is writable
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			limit_ff <= LIMIT_RESET; // RULE_03
		else if (reg_wr_en && reg_addr == ADDR_SLEW_LIMIT)
			limit_ff <= reg_wdata[LIMIT_MSB:LIMIT_LSB]; // RULE_02
	end

	// read mux; reserved bits and foreign addresses read zero
	always_comb
	begin
		nxt_rdata = 16'h0000;
		nxt_hit   = 1'b1;
		unique case (reg_addr)
			ADDR_SLEW_LIMIT:
				nxt_rdata = {1'b0, limit_ff, 2'b00}; // RULE_02
			ADDR_SERIAL_HIGH:
				nxt_rdata = TRACEABILITY_SERIAL[SERIAL_HIGH_LSB +: REG_W]; // RULE_05
			ADDR_SERIAL_MID:
				nxt_rdata = TRACEABILITY_SERIAL[SERIAL_MID_LSB +: REG_W]; // RULE_06
			ADDR_SERIAL_LOW:
				nxt_rdata = TRACEABILITY_SERIAL[SERIAL_LOW_LSB +: REG_W]; // RULE_07
			ADDR_PART_IDENTITY:
				nxt_rdata = {REVISION, PART_CODE}; // RULE_08
			default:
				nxt_hit   = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata_ff  <= 16'h0000;
			reg_rd_hit_ff <= 1'b0;
		end
		else if (reg_rd_en)
		begin
			reg_rdata_ff  <= nxt_rdata;
			reg_rd_hit_ff <= nxt_hit;
		end
	end

	// difference of consecutive signed results, one bit wider
	assign diff   = {temp_result[TEMP_W-1], temp_result}
		- {prev_temp_ff[TEMP_W-1], prev_temp_ff}; // RULE_11
	assign rising = prev_valid_ff && !diff[TEMP_W] && (diff != 15'h0); // RULE_11

	// diff*1000/period > limit  <=>  diff*1000 > limit*period
	assign rise_scaled  = scale(PROD_W'(diff[TEMP_W-1:0]), PROD_W'(MS_PER_S_W)); // RULE_01
	assign limit_scaled = scale(PROD_W'(limit_ff), PROD_W'(cycle_period_ff)); // RULE_01

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_temp_ff  <= 14'h0000;
			prev_valid_ff <= 1'b0;
		end
		else if (temp_valid)
		begin
			prev_temp_ff  <= temp_result;
			prev_valid_ff <= 1'b1;
		end
	end

	// condition re-evaluated at each conversion completion
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			slew_status_ff <= 1'b0;
		else if (temp_valid)
			slew_status_ff <= rising && (rise_scaled > limit_scaled); // RULE_04
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			slew_alert_ff <= 1'b0;
		else
			slew_alert_ff <= slew_status_ff && slew_alert_en; // RULE_12
	end
endmodule : slew_limit_and_id_registers
`default_nettype wire

// file: sim/temp_source_model.sv
// conversion front end answering each start with a result
`timescale 1ns/1ps
`default_nettype none
module temp_source_model
(
	input  wire logic        mclk,       // clock
	input  wire logic        rst_n,      // reset
	input  wire logic        conv_start, // start
	input  wire logic [13:0] next_temp,  // value
	output logic             valid_ff,   // done pulse
	output logic [13:0]      result_ff   // inverted when idle
);
	logic [1:0] wait_ff;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_ff   <= 2'h0;
			valid_ff  <= 1'b0;
			result_ff <= 14'h0000;
		end
		else
		begin
			wait_ff   <= conv_start ? 2'h3 : wait_ff - {1'b0, |wait_ff};
			valid_ff  <= wait_ff == 2'h1;
			result_ff <= wait_ff == 2'h1 ? next_temp : ~next_temp;
		end
	end
endmodule : temp_source_model
`default_nettype wire

// file: sim/slew_id_sva.sv
// assertions on the slew limit and identity register ports
`timescale 1ns/1ps
`default_nettype none
module slew_id_sva
#(
	parameter logic [47:0] SER = 48'h0, // serial number
	parameter logic [3:0]  REV = 4'h0,  // revision
	parameter logic [11:0] PC  = 12'h0  // part code
)
(
	input wire logic        mclk,           // clock
	input wire logic        rst_n,          // reset
	input wire logic [7:0]  reg_addr,       // address
	input wire logic        reg_rd_en,      // read strobe
	input wire logic [15:0] reg_rdata_ff,   // read data
	input wire logic        reg_rd_hit_ff,  // read hit
	input wire logic        slew_alert_en,  // enable
	input wire logic        temp_valid,     // result pulse
	input wire logic        slew_status_ff, // raw slew
	input wire logic        slew_alert_ff   // gated slew
);
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_alert_gate: assert property (slew_alert_ff == $past(slew_status_ff & slew_alert_en))
		else $error("alert not gated status");
	a_status_hold: assert property (!$past(temp_valid) |-> $stable(slew_status_ff))
		else $error("status moved without result");
	a_rdata_hold: assert property (!$past(reg_rd_en) |-> $stable(reg_rdata_ff))
		else $error("read data moved without read");
	a_hit_range: assert property ($past(reg_rd_en) |->
		reg_rd_hit_ff == ($past(reg_addr) inside {[8'h08:8'h0c]}))
		else $error("read hit wrong");
	a_limit_rsvd: assert property (($past(reg_rd_en) && $past(reg_addr) == 8'h08) |->
		!reg_rdata_ff[15] && !reg_rdata_ff[1:0])
		else $error("reserved limit bits set");
	a_serial_high: assert property (($past(reg_rd_en) && $past(reg_addr) == 8'h09) |->
		reg_rdata_ff == SER[47:32])
		else $error("serial high wrong");
	a_serial_mid: assert property (($past(reg_rd_en) && $past(reg_addr) == 8'h0a) |->
		reg_rdata_ff == SER[31:16])
		else $error("serial mid wrong");
	a_serial_low: assert property (($past(reg_rd_en) && $past(reg_addr) == 8'h0b) |->
		reg_rdata_ff == SER[15:0])
		else $error("serial low wrong");
	a_part_ident: assert property (($past(reg_rd_en) && $past(reg_addr) == 8'h0c) |->
		reg_rdata_ff == {REV, PC})
		else $error("identity wrong");
endmodule : slew_id_sva
bind slew_limit_and_id_registers slew_id_sva #(.SER(TRACEABILITY_SERIAL), .REV(REVISION),
	.PC(PART_CODE)) i_slew_id_sva (.mclk, .rst_n, .reg_addr, .reg_rd_en, .reg_rdata_ff,
	.reg_rd_hit_ff, .slew_alert_en, .temp_valid, .slew_status_ff, .slew_alert_ff);
`default_nettype wire

// file: sim/slew_limit_and_id_registers_tb.sv
// self-checking bench for the slew limit and identity registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	$display("[FAIL] %s exp %h got %h", n, e, g); err_count++; end end
module slew_limit_and_id_registers_tb;
	import slew_id_pkg::*;
	localparam logic [47:0] SER = 48'h3c1d_9e27_b4f8; // arbitrary
	localparam logic [15:0] IDW = 16'h53e9;           // arbitrary
	localparam int          MSC = 4;                  // cycles per ms in simulation
	logic        mclk, rst_n, wr_en, rd_en, en, valid, start, status, alert, hit;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata;
	logic [13:0] temp, result;
	int          err_count, compares;
	int          cyc, first_start, t0, t1;
	logic [10:0] period;
	slew_limit_and_id_registers #(.MS_CYC(MSC), .TRACEABILITY_SERIAL(SER),
		.REVISION(IDW[15:12]), .PART_CODE(IDW[11:0])) i_slew_limit_and_id_registers (
		.mclk, .rst_n, .reg_addr(addr), .reg_wr_en(wr_en), .reg_wdata(wdata),
		.reg_rd_en(rd_en), .reg_rdata_ff(rdata), .reg_rd_hit_ff(hit), .slew_alert_en(en),
		.conv_period_ms(period), .temp_valid(valid), .temp_result(result),
		.conv_start_ff(start), .slew_status_ff(status), .slew_alert_ff(alert));
	temp_source_model i_temp_source_model (.mclk, .rst_n, .conv_start(start),
		.next_temp(temp), .valid_ff(valid), .result_ff(result));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic results();
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge mclk);
		wr_en = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic h);
		addr = a;
		rd_en = 1'b1;
		@(negedge mclk);
		rd_en = 1'b0;
		`CHK("rdata", e, rdata)
		`CHK("hit", h, hit)
	endtask : rd
	// waits for the next result carrying t, then lets status settle
	task automatic conv(input logic [13:0] t);
		temp = t;
		for (int i = 0; i < 5000 && valid !== 1'b1; i++)
			@(negedge mclk);
		if (valid !== 1'b1)
		begin
			err_count++;
			results();
		end
		@(negedge mclk);
	endtask : conv
	// cycles since reset release, and the cycle of the first start
	always @(posedge mclk)
	begin
		if (!rst_n)
		begin
			cyc         <= 0;
			first_start <= 0;
		end
		else
		begin
			cyc <= cyc + 1;
			if (start === 1'b1 && first_start == 0)
				first_start <= cyc;
		end
	end
	// skips the current pulse, then returns the cycle of the next start
	task automatic next_start(output int t);
		@(negedge mclk);
		for (int i = 0; i < 9000 && start !== 1'b1; i++)
			@(negedge mclk);
		if (start !== 1'b1)
		begin
			err_count++;
			results();
		end
		t = cyc;
	endtask : next_start
	initial
	begin
		{rst_n, wr_en, rd_en, en} = 4'h0;
		addr = 8'h00;
		wdata = 16'h0000;
		temp = 14'h0000;
		period = PERIOD_MIN_MS;
		err_count = 0;
		compares = 0;
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		rd(ADDR_SLEW_LIMIT, SLEW_REG_RESET, 1'b1);
		wr(ADDR_SLEW_LIMIT, 16'hffff);
		rd(ADDR_SLEW_LIMIT, 16'h7ffc, 1'b1);
		wr(ADDR_SLEW_LIMIT, 16'h0004);
		rd(ADDR_SLEW_LIMIT, 16'h0004, 1'b1);
		wr(ADDR_SERIAL_LOW, 16'hffff);
		rd(ADDR_SERIAL_HIGH, SER[47:32], 1'b1);
		rd(ADDR_SERIAL_MID, SER[31:16], 1'b1);
		rd(ADDR_SERIAL_LOW, SER[15:0], 1'b1);
		rd(ADDR_PART_IDENTITY, IDW, 1'b1);
		rd(8'h0d, 16'h0000, 1'b0);
		wr(ADDR_SLEW_LIMIT, SLEW_REG_RESET);
		conv(14'd100);
		`CHK("status", 1'b0, status)
		// 6 ms period, limit 320: a rise of 1 stays under, 2 goes over
		conv(14'd101);
		`CHK("status", 1'b0, status)
		conv(14'd103);
		`CHK("status", 1'b1, status)
		`CHK("alert", 1'b0, alert)
		en = 1'b1;
		@(negedge mclk);
		`CHK("alert", 1'b1, alert)
		conv(14'd90);
		`CHK("status", 1'b0, status)
		`CHK("first start", PERIOD_DEFAULT_MS * MSC + 1, first_start)
		// a new period takes effect from the start after the request
		period = 11'h008;
		next_start(t0);
		next_start(t1);
		`CHK("period", 8 * MSC, t1 - t0)
		period = 11'h002;
		next_start(t0);
		next_start(t1);
		`CHK("period min", PERIOD_MIN_MS * MSC, t1 - t0)
		period = 11'h7ff;
		next_start(t0);
		rd(ADDR_SERIAL_MID, SER[31:16], 1'b1);
		next_start(t1);
		`CHK("period max", PERIOD_MAX_MS * MSC, t1 - t0)
		results();
	end
endmodule : slew_limit_and_id_registers_tb
`default_nettype wire
